/* File: rtl/stoem_consts.svh */
`ifndef STOEM_CONSTS_SVH
`define STOEM_CONSTS_SVH

// ****************************************************************
// Axis count and timing.
// ****************************************************************
`define STOEM_NAX               3
`define STOEM_CNT_W             24
`define STOEM_CLK_HZ            100000000
`define STOEM_REACT_DELAY_MS    100
`define STOEM_REACT_DELAY_CYC   (`STOEM_CLK_HZ / 1000 * `STOEM_REACT_DELAY_MS)
`define STOEM_HW_OFF_MAX_MS     5
`define STOEM_SW_OFF_MAX_MS     3

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define STOEM_ADDR_W            8
`define STOEM_OFS_CFG           8'h00
`define STOEM_OFS_CTRL          8'h04
`define STOEM_OFS_STAT          8'h08
`define STOEM_OFS_IO            8'h0C
`define STOEM_OFS_INT_STAT      8'h10
`define STOEM_OFS_INT_MASK      8'h14
`define STOEM_OFS_EVID          8'h18

// ****************************************************************
// Field positions.
// ****************************************************************
`define STOEM_CFG_REACT_LSB     0
`define STOEM_CFG_THREE_AX_BIT  8
`define STOEM_CTRL_ACK_LSB      0
`define STOEM_STAT_ERR_OFF_LSB  0
`define STOEM_STAT_WARN_LSB     4
`define STOEM_STAT_ERR_ON_LSB   8
`define STOEM_STAT_ZSW15_LSB    12
`define STOEM_STAT_REQ_LSB      16
`define STOEM_IO_CHA_LSB        0
`define STOEM_IO_CHB_LSB        4
`define STOEM_IO_SOB_LSB        8
`define STOEM_INT_W             9

// ****************************************************************
// Reset values and event reporting.
// ****************************************************************
`define STOEM_RST_REACT         3'h0
`define STOEM_RST_THREE_AX      1'h0
`define STOEM_RST_INT_MASK      9'h000
`define STOEM_EVENT_ID          8'hE1
`define STOEM_WARN_WORD         4'h8
`define STOEM_WARN_BIT          4'h1
`define STOEM_OBJ_REACTION      16'h22FB
`define STOEM_OBJ_STATUS_WORD   16'h6041
`define STOEM_OBJ_DIG_INPUTS    16'h60FD

`endif

/* File: rtl/stoem_monitor.sv */
// Summary of operation
// - Torque-off request is active when channel A or B or both are low.
// - A safety option board torque-off command also counts as an active request.
// - Input-triggered error or warning reaction waits 100 ms after request activation; a board command reacts one cycle after activation instead.
// - Hardware torque-off output follows the request well within 5 ms.
// - Power stage disabled and brake engaged within 3 ms of a request.
// - Power-off-state request raises the error when the reaction setting is 1.
// - Power-off-state request raises the warning when the reaction setting is 0.
// - Reaction setting per axis is software writable configuration.
// - After the delay the profile status word bit 15 shows the event; on a board command the code sets it one cycle after activation.
// - Power-on attempt in error state with request present raises the active error.
// - Request during an ongoing power-on from power-off counts as powered state.
// - Power-off state means the switch-on-disabled state of the profile machine.
// - Channel states are readable by software.
// - On the three-axis variant axis 3 uses the channels of axis 2.
// - On error the control loops are disabled; the error is acknowledgeable.
// - Error reports event identifier 225 and warning word 8 bit 1.
//
// The implementer's own choices: the APB register port and the register offsets.

`include "stoem_consts.svh"

`default_nettype none

module stoem_monitor
    import stoem_pkg::*;
#(
    parameter int unsigned REACT_DELAY_CYCLES = `STOEM_REACT_DELAY_CYC
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic [`STOEM_NAX-1:0]     sto_a_n,
    input  wire logic [`STOEM_NAX-1:0]     sto_b_n,
    input  wire logic [`STOEM_NAX-1:0]     safety_option_board_sto,
    input  wire logic [`STOEM_NAX-1:0]     axis_switch_on_disabled,
    input  wire logic [`STOEM_NAX-1:0]     axis_power_on_pending,
    input  wire logic [`STOEM_NAX-1:0]     axis_power_on_req,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`STOEM_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    output logic      [`STOEM_NAX-1:0]     torque_off,
    output logic      [`STOEM_NAX-1:0]     power_stage_en,
    output logic      [`STOEM_NAX-1:0]     brake_engage,
    output logic      [`STOEM_NAX-1:0]     control_loops_en,
    output logic      [`STOEM_NAX-1:0]     profile_status_word_bit15,
    output logic      [`STOEM_NAX-1:0]     err_power_off,
    output logic      [`STOEM_NAX-1:0]     warn_power_off,
    output logic      [`STOEM_NAX-1:0]     err_sto_active,
    output logic                           irq
);

    localparam logic [`STOEM_CNT_W-1:0] DLY = REACT_DELAY_CYCLES[`STOEM_CNT_W-1:0];

    stoem_state_s s;
    stoem_state_s next_s;

    logic [`STOEM_NAX-1:0] rq;

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    always_comb begin
        logic                    acc;
        logic                    wr;
        logic [`STOEM_NAX-1:0]   ack;
        logic [`STOEM_INT_W-1:0] int_clr;
        logic [`STOEM_INT_W-1:0] int_set;
        logic                    fire;
        int                      p;
        acc     = psel & penable;
        wr      = acc & s.pready & pwrite;
        ack     = '0;
        int_clr = '0;
        int_set = '0;
        fire    = 1'b0;
        p       = 0;
        rq      = '0;
        next_s  = s;

        // Three-stage pin synchronisers; a change counts once stages two and three agree.
        next_s.a1 = sto_a_n;
        next_s.a2 = s.a1;
        next_s.a3 = s.a2;
        next_s.b1 = sto_b_n;
        next_s.b2 = s.b1;
        next_s.b3 = s.b2;
        next_s.s1 = safety_option_board_sto;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int i = 0; i < `STOEM_NAX; i++) begin
            if (s.a2[i] == s.a3[i]) begin
                next_s.af[i] = s.a3[i];
            end
            if (s.b2[i] == s.b3[i]) begin
                next_s.bf[i] = s.b3[i];
            end
            if (s.s2[i] == s.s3[i]) begin
                next_s.sf[i] = s.s3[i];
            end
        end

        // APB slave with one wait state; reads are registered.
        next_s.pready  = acc & ~s.pready;
        next_s.pslverr = 1'b0;
        next_s.prdata  = 32'h00000000;
        if (acc && !s.pready) begin
            unique case (paddr)
                `STOEM_OFS_CFG: begin
                    next_s.prdata = (32'(s.reaction) << `STOEM_CFG_REACT_LSB)
                                  | (32'(s.three_axis) << `STOEM_CFG_THREE_AX_BIT);
                end
                `STOEM_OFS_CTRL: begin
                    next_s.prdata = 32'h00000000;
                end
                `STOEM_OFS_STAT: begin
                    next_s.prdata = (32'(s.err_off) << `STOEM_STAT_ERR_OFF_LSB)
                                  | (32'(s.warn_off) << `STOEM_STAT_WARN_LSB)
                                  | (32'(s.err_on) << `STOEM_STAT_ERR_ON_LSB)
                                  | (32'(s.zsw15) << `STOEM_STAT_ZSW15_LSB)
                                  | (32'(s.req) << `STOEM_STAT_REQ_LSB);
                end
                `STOEM_OFS_IO: begin
                    next_s.prdata = (32'(s.af) << `STOEM_IO_CHA_LSB)
                                  | (32'(s.bf) << `STOEM_IO_CHB_LSB)
                                  | (32'(s.sf) << `STOEM_IO_SOB_LSB);
                end
                `STOEM_OFS_INT_STAT: begin
                    next_s.prdata = 32'(s.int_stat);
                end
                `STOEM_OFS_INT_MASK: begin
                    next_s.prdata = 32'(s.int_mask);
                end
                `STOEM_OFS_EVID: begin
                    next_s.prdata = {16'h0000, `STOEM_WARN_BIT, `STOEM_WARN_WORD, `STOEM_EVENT_ID};
                end
                default: begin
                    next_s.pslverr = 1'b1;
                end
            endcase
        end
        if (wr) begin
            unique case (paddr)
                `STOEM_OFS_CFG: begin
                    next_s.reaction   = pwdata[`STOEM_CFG_REACT_LSB +: `STOEM_NAX];
                    next_s.three_axis = pwdata[`STOEM_CFG_THREE_AX_BIT];
                end
                `STOEM_OFS_CTRL: begin
                    ack = pwdata[`STOEM_CTRL_ACK_LSB +: `STOEM_NAX];
                end
                `STOEM_OFS_INT_STAT: begin
                    int_clr = pwdata[`STOEM_INT_W-1:0];
                end
                `STOEM_OFS_INT_MASK: begin
                    next_s.int_mask = pwdata[`STOEM_INT_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Per-axis request evaluation and delayed reaction.
        for (int i = 0; i < `STOEM_NAX; i++) begin
            p     = (i == 2 && s.three_axis) ? 1 : i;
            rq[i] = ~s.af[p] | ~s.bf[p] | s.sf[i];
            next_s.req[i] = rq[i];
            if (rq[i] && !s.req[i]) begin
                next_s.cls_off[i] = axis_switch_on_disabled[i] & ~axis_power_on_pending[i];
            end else if (rq[i] && !s.fired[i] && axis_switch_on_disabled[i] && !axis_power_on_pending[i]) begin
                next_s.cls_off[i] = 1'b1;
            end
            fire = 1'b0;
            if (!rq[i]) begin
                next_s.cnt[i]      = '0;
                next_s.fired[i]    = 1'b0;
                next_s.zsw15[i]    = 1'b0;
                next_s.warn_off[i] = 1'b0;
                if (ack[i]) begin
                    next_s.err_off[i] = 1'b0;
                    next_s.err_on[i]  = 1'b0;
                end
            end else if (!s.fired[i]) begin
                next_s.cnt[i] = s.cnt[i] + 24'h000001;
                fire = s.req[i] & (s.sf[i] | (s.cnt[i] == DLY));
            end
            if (fire) begin
                next_s.fired[i] = 1'b1;
                next_s.zsw15[i] = 1'b1;
                if (s.cls_off[i] && s.reaction[i]) begin
                    next_s.err_off[i] = 1'b1;
                    int_set[i]        = 1'b1;
                end else if (s.cls_off[i]) begin
                    next_s.warn_off[i] = 1'b1;
                    int_set[i + 3]     = 1'b1;
                end else begin
                    next_s.err_on[i] = 1'b1;
                    int_set[i + 6]   = 1'b1;
                end
            end
            if (axis_power_on_req[i] && rq[i] && (s.err_off[i] || s.err_on[i])) begin
                next_s.err_on[i] = 1'b1;
                int_set[i + 6]   = 1'b1;
            end
            next_s.torque_off[i] = rq[i];
            next_s.brake[i]      = rq[i];
            next_s.pstage_en[i]  = ~rq[i] & ~next_s.err_off[i] & ~next_s.err_on[i];
            next_s.loops_en[i]   = ~next_s.err_off[i] & ~next_s.err_on[i];
        end

        // Sticky interrupt flags; a new event wins over a clear.
        next_s.int_stat = (s.int_stat & ~int_clr) | int_set;
        next_s.irq      = |(next_s.int_stat & next_s.int_mask);
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s            <= '0;
            s.a1         <= '1;
            s.a2         <= '1;
            s.a3         <= '1;
            s.b1         <= '1;
            s.b2         <= '1;
            s.b3         <= '1;
            s.af         <= '1;
            s.bf         <= '1;
            s.pstage_en  <= '1;
            s.loops_en   <= '1;
            s.reaction   <= `STOEM_RST_REACT;
            s.three_axis <= `STOEM_RST_THREE_AX;
            s.int_mask   <= `STOEM_RST_INT_MASK;
        end else begin
            s <= next_s;
        end
    end

    assign prdata                    = s.prdata;
    assign pready                    = s.pready;
    assign pslverr                   = s.pslverr;
    assign torque_off                = s.torque_off;
    assign power_stage_en            = s.pstage_en;
    assign brake_engage              = s.brake;
    assign control_loops_en          = s.loops_en;
    assign profile_status_word_bit15 = s.zsw15;
    assign err_power_off             = s.err_off;
    assign warn_power_off            = s.warn_off;
    assign err_sto_active            = s.err_on;
    assign irq                       = s.irq;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (rst);

    property p_chan_low;
        !s.af[0] |-> ##1 torque_off[0];
    endproperty
    a_chan_low: assert property (p_chan_low) else $error("channel A low did not set torque off");

    property p_sob_cmd;
        s.sf[2] |-> ##1 torque_off[2];
    endproperty
    a_sob_cmd: assert property (p_sob_cmd) else $error("board command did not set torque off");

    property p_hw_off;
        (!sto_a_n[0])[*5] |-> ##[0:2] torque_off[0];
    endproperty
    a_hw_off: assert property (p_hw_off) else $error("torque off too late after pin low");

    property p_stage_brake;
        torque_off[0] |-> (!power_stage_en[0] && brake_engage[0]);
    endproperty
    a_stage_brake: assert property (p_stage_brake) else $error("power stage or brake wrong");

    property p_err_off;
        $rose(err_power_off[0]) |-> (s.reaction[0] && s.cls_off[0] && profile_status_word_bit15[0]);
    endproperty
    a_err_off: assert property (p_err_off) else $error("power off error without cause");

    property p_warn_off;
        $rose(warn_power_off[0]) |-> (!s.reaction[0] && s.cls_off[0] && !err_power_off[0]);
    endproperty
    a_warn_off: assert property (p_warn_off) else $error("power off warning without cause");

    property p_zsw_delay;
        $rose(profile_status_word_bit15[0]) |-> ($past(s.cnt[0]) == DLY) || $past(s.sf[0]);
    endproperty
    a_zsw_delay: assert property (p_zsw_delay) else $error("status bit 15 set before delay");

    property p_cnt_restart;
        !s.req[0] |-> (s.cnt[0] == '0 && !profile_status_word_bit15[0]);
    endproperty
    a_cnt_restart: assert property (p_cnt_restart) else $error("delay counter not restarted");

    property p_power_on_err;
        (axis_power_on_req[0] && rq[0] && (err_power_off[0] || err_sto_active[0])) |=> err_sto_active[0];
    endproperty
    a_power_on_err: assert property (p_power_on_err) else $error("power on in error missed");

    property p_loops_off;
        (err_sto_active[0] || err_power_off[0]) |-> !control_loops_en[0];
    endproperty
    a_loops_off: assert property (p_loops_off) else $error("control loops left enabled");

    property p_chan_b_low;
        !s.bf[0] |-> ##1 torque_off[0];
    endproperty
    a_chan_b_low: assert property (p_chan_b_low) else $error("channel B low did not set torque off");

    property p_stage_timing;
        (!sto_b_n[1])[*5] |-> ##[0:2] (!power_stage_en[1] && brake_engage[1]);
    endproperty
    a_stage_timing: assert property (p_stage_timing) else $error("stage or brake late after pin low");

    property p_err_irq;
        $rose(err_power_off[0]) |-> s.int_stat[0];
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("power off error without status flag");

    property p_sob_fast;
        (s.req[2] && s.sf[2]) |-> ##1 profile_status_word_bit15[2];
    endproperty
    a_sob_fast: assert property (p_sob_fast) else $error("board request reaction was delayed");

    property p_linked_axis;
        (s.three_axis && !s.af[1]) |-> ##1 torque_off[2];
    endproperty
    a_linked_axis: assert property (p_linked_axis) else $error("axis 3 did not follow axis 2");

endmodule

`default_nettype wire

/* File: rtl/stoem_pkg.sv */
`include "stoem_consts.svh"

`default_nettype none

package stoem_pkg;

    // ****************************************************************
    // Complete state of the monitor.
    // ****************************************************************
    typedef struct packed {
        logic [`STOEM_NAX-1:0]                    a1;
        logic [`STOEM_NAX-1:0]                    a2;
        logic [`STOEM_NAX-1:0]                    a3;
        logic [`STOEM_NAX-1:0]                    b1;
        logic [`STOEM_NAX-1:0]                    b2;
        logic [`STOEM_NAX-1:0]                    b3;
        logic [`STOEM_NAX-1:0]                    s1;
        logic [`STOEM_NAX-1:0]                    s2;
        logic [`STOEM_NAX-1:0]                    s3;
        logic [`STOEM_NAX-1:0]                    af;
        logic [`STOEM_NAX-1:0]                    bf;
        logic [`STOEM_NAX-1:0]                    sf;
        logic [`STOEM_NAX-1:0]                    req;
        logic [`STOEM_NAX-1:0]                    cls_off;
        logic [`STOEM_NAX-1:0]                    fired;
        logic [`STOEM_NAX-1:0][`STOEM_CNT_W-1:0]  cnt;
        logic [`STOEM_NAX-1:0]                    zsw15;
        logic [`STOEM_NAX-1:0]                    err_off;
        logic [`STOEM_NAX-1:0]                    warn_off;
        logic [`STOEM_NAX-1:0]                    err_on;
        logic [`STOEM_NAX-1:0]                    torque_off;
        logic [`STOEM_NAX-1:0]                    pstage_en;
        logic [`STOEM_NAX-1:0]                    brake;
        logic [`STOEM_NAX-1:0]                    loops_en;
        logic [`STOEM_NAX-1:0]                    reaction;
        logic                                     three_axis;
        logic [`STOEM_INT_W-1:0]                  int_stat;
        logic [`STOEM_INT_W-1:0]                  int_mask;
        logic                                     pready;
        logic                                     pslverr;
        logic [31:0]                              prdata;
        logic                                     irq;
    } stoem_state_s;

endpackage

`default_nettype wire

/* File: tb/stoem_far_side.sv */
`include "stoem_consts.svh"

`default_nettype none

// ****************************************************************
// Safety circuit and supervising controller seen by the monitor.
// ****************************************************************
module stoem_far_side
    import stoem_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic [`STOEM_NAX-1:0]     open_a,
    input  wire logic [`STOEM_NAX-1:0]     open_b,
    input  wire logic [`STOEM_NAX-1:0]     board_cmd,
    input  wire logic [`STOEM_NAX-1:0]     in_power_off,
    input  wire logic [`STOEM_NAX-1:0]     power_on_busy,
    input  wire logic [`STOEM_NAX-1:0]     try_on,
    output var  logic [`STOEM_NAX-1:0]     sto_a_n,
    output var  logic [`STOEM_NAX-1:0]     sto_b_n,
    output var  logic [`STOEM_NAX-1:0]     safety_option_board_sto,
    output var  logic [`STOEM_NAX-1:0]     axis_switch_on_disabled,
    output var  logic [`STOEM_NAX-1:0]     axis_power_on_pending,
    output var  logic [`STOEM_NAX-1:0]     axis_power_on_req
);
    logic [`STOEM_NAX-1:0] try_q;

    // Everything changes just after a rising edge; a power-on attempt is one pulse.
    always @(posedge sys_clk) begin
        sto_a_n <= ~open_a;
        sto_b_n <= ~open_b;
        safety_option_board_sto <= board_cmd;
        axis_switch_on_disabled <= in_power_off;
        axis_power_on_pending <= power_on_busy;
        axis_power_on_req <= try_on & ~try_q;
        try_q <= try_on;
    end
endmodule

`default_nettype wire

/* File: tb/stoem_monitor_tb.sv */
`include "stoem_consts.svh"

`default_nettype none

module stoem_monitor_tb
    import stoem_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int D = 20;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, irq;
    logic [2:0] open_a = 3'h0, open_b = 3'h0, board_cmd = 3'h0, in_off = 3'h7, pend = 3'h0, try_on = 3'h0;
    logic [2:0] a_n, b_n, safety_option_board, sod, pnd, pon;
    logic [2:0] torque_off, power_stage_en, brake_engage, control_loops_en, bit15, err_off, warn, err_on;
    int fails = 0;
    int comparisons = 0;

    always #5 sys_clk = ~sys_clk;

    stoem_far_side i_stoem_far_side (.sys_clk(sys_clk), .open_a(open_a), .open_b(open_b),
        .board_cmd(board_cmd), .in_power_off(in_off), .power_on_busy(pend), .try_on(try_on),
        .sto_a_n(a_n), .sto_b_n(b_n), .safety_option_board_sto(safety_option_board), .axis_switch_on_disabled(sod),
        .axis_power_on_pending(pnd), .axis_power_on_req(pon));

    stoem_monitor #(.REACT_DELAY_CYCLES(D)) i_stoem_monitor (.sys_clk(sys_clk), .rst(rst),
        .sto_a_n(a_n), .sto_b_n(b_n), .safety_option_board_sto(safety_option_board), .axis_switch_on_disabled(sod),
        .axis_power_on_pending(pnd), .axis_power_on_req(pon), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .torque_off(torque_off), .power_stage_en(power_stage_en),
        .brake_engage(brake_engage), .control_loops_en(control_loops_en),
        .profile_status_word_bit15(bit15), .err_power_off(err_off), .warn_power_off(warn),
        .err_sto_active(err_on), .irq(irq));

    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "read data");
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        fails++;
        give_verdict();
    end

    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        cyc(2);
        rst <= 1'b0;
        cyc(5);
        rdc(`STOEM_OFS_CFG, 32'h0);
        rdc(`STOEM_OFS_INT_MASK, 32'h0);
        rdc(`STOEM_OFS_EVID, 32'h000018E1);
        apb(1'b0, 8'h1C, 32'h0);
        chk(er, 1'b1, "unmapped error");
        apb(1'b1, `STOEM_OFS_CFG, 32'h1);
        apb(1'b1, `STOEM_OFS_INT_MASK, 32'h1FF);
        rdc(`STOEM_OFS_CFG, 32'h1);
        open_a <= 3'h1;
        cyc(8);
        chk(torque_off, 3'h1, "torque off");
        chk({brake_engage, power_stage_en}, 6'h0E, "brake and stage");
        chk(bit15, 3'h0, "early status");
        rdc(`STOEM_OFS_IO, 32'h00000076);
        cyc(D);
        chk(bit15, 3'h1, "status bit");
        chk({err_off, warn, control_loops_en, irq}, 10'h08D, "power-off error");
        rdc(`STOEM_OFS_STAT, 32'h00011001);
        try_on <= 3'h1;
        cyc(1);
        try_on <= 3'h0;
        cyc(4);
        chk(err_on, 3'h1, "power-on attempt error");
        apb(1'b1, `STOEM_OFS_CTRL, 32'h1);
        cyc(2);
        chk(err_off, 3'h1, "ack refused");
        open_a <= 3'h0;
        cyc(8);
        apb(1'b1, `STOEM_OFS_CTRL, 32'h1);
        cyc(2);
        chk({err_off, err_on, control_loops_en}, 9'h007, "ack cleared");
        apb(1'b1, `STOEM_OFS_INT_STAT, 32'h1FF);
        cyc(2);
        chk(irq, 1'b0, "irq cleared");
        open_b <= 3'h2;
        cyc(D + 12);
        chk({warn, err_off, irq}, 7'h21, "warning");
        rdc(`STOEM_OFS_INT_STAT, 32'h00000010);
        apb(1'b1, `STOEM_OFS_INT_MASK, 32'h0);
        cyc(2);
        chk(irq, 1'b0, "irq masked");
        apb(1'b1, `STOEM_OFS_INT_MASK, 32'h1FF);
        apb(1'b1, `STOEM_OFS_INT_STAT, 32'h1FF);
        open_b <= 3'h0;
        cyc(8);
        chk({warn, bit15, irq}, 7'h0, "warning dropped");
        open_a <= 3'h4;
        cyc(15);
        open_a <= 3'h0;
        cyc(10);
        open_a <= 3'h4;
        cyc(15);
        chk(bit15, 3'h0, "delay restarted");
        cyc(D);
        chk({bit15, warn}, 6'h24, "sustained request");
        open_a <= 3'h0;
        cyc(8);
        pend <= 3'h4;
        board_cmd <= 3'h4;
        cyc(12);
        chk({torque_off, bit15}, 6'h24, "board request");
        chk({err_on, err_off}, 6'h20, "pending power-on class");
        board_cmd <= 3'h0;
        pend <= 3'h0;
        cyc(8);
        apb(1'b1, `STOEM_OFS_CTRL, 32'h4);
        cyc(2);
        chk(err_on, 3'h0, "board error cleared");
        apb(1'b1, `STOEM_OFS_CFG, 32'h100);
        open_a <= 3'h2;
        cyc(8);
        chk(torque_off, 3'h6, "axis 3 linked");
        open_a <= 3'h0;
        cyc(8);
        chk(torque_off, 3'h0, "linked release");
        in_off <= 3'h4;
        open_b <= 3'h3;
        cyc(12);
        in_off <= 3'h5;
        cyc(D);
        chk({err_on, warn, err_off}, 9'h0A8, "power off during delay");
        give_verdict();
    end
endmodule

`default_nettype wire
